// file: acmp_control.sv
// Notes on behaviour
// - Raw result high when positive exceeds negative
// - Invert bit inverts the presented output
// - Flag set on selected output edge
// - Control read clears flag; writes ignored
// - Interrupt needs flag and enable set
// - Interrupt edge follows output by 250ns
// - Powered off output reads as one
// - Power bit switches comparator power output and, when clear, forces the output to one
// - Pin enable routes output to port pin
// - Output feeds timer break input
// - Stored bit reflects output, reset clears
// - Hysteresis bit set at reset
// - External reference wins over all
// - Bandgap reference when bandgap bit set, external clear
// - Level code picks sixteen levels
`timescale 1ns/1ps
module acmp_control (
    // Clock, reset and enable
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic              ce_in,
    // Register port
    input  wire logic [7:0]        addr_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [7:0]        rdata_out,
    // Analog core
    input  wire logic              raw_result_in,
    output logic                   comparator_power_out,
    output logic                   hysteresis_enable_out,
    output acmp_pkg::acmp_ref_t    reference_out,
    // Output routing
    output logic                   port_a_pin_seven_out,
    output logic                   port_a_pin_seven_oe_out,
    output logic                   timer_break_out,
    // Interrupts
    output logic                   comparator_irq_out,
    output logic                   event_irq_out
);

    acmp_pkg::acmp_bus_t bus;
    logic [7:0]  ref_select_reg;
    logic [7:0]  control_reg;
    logic        sync1_reg;
    logic        sync2_reg;
    logic        result_output_reg;
    logic        result_prev_reg;
    logic        flag_reg;
    logic        irq_reg;
    logic [7:0]  rdata_reg;
    logic [acmp_pkg::EV_W-1:0] ev_status_reg;
    logic [acmp_pkg::EV_W-1:0] ev_enable_reg;
    logic [acmp_pkg::EV_W-1:0] ev_next;
    logic        result_next;
    logic        edge_hit;
    logic        delayed_result;
    logic        delayed_prev_reg;
    logic        ctrl_rd;

    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] target);
        addr_is = (a == target);
    endfunction : addr_is

    // ------------------------------------------------------------------
    // Synchronizer
    // ------------------------------------------------------------------
    // Two flop sync
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (ce_in) begin
            sync1_reg <= raw_result_in;
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------------
    // Output value
    // ------------------------------------------------------------------
    always_comb begin
        result_next = sync2_reg;
        if (control_reg[acmp_pkg::CC_INV]) begin
            result_next = ~sync2_reg;
        end
        if (!control_reg[acmp_pkg::CC_POWER]) begin
            result_next = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            result_output_reg <= 1'b1;
            result_prev_reg   <= 1'b1;
        end else if (ce_in) begin
            result_output_reg <= result_next;
            result_prev_reg   <= result_output_reg;
        end
    end

    acmp_delay #(
        .DEPTH (acmp_pkg::IRQ_DELAY_CYC)
    ) u_delay (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .enable_in (ce_in),
        .d_in      (result_output_reg),
        .q_out     (delayed_result)
    );

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            delayed_prev_reg <= 1'b1;
        end else if (ce_in) begin
            delayed_prev_reg <= delayed_result;
        end
    end

    assign edge_hit = control_reg[acmp_pkg::CC_INV]
                    ? (delayed_prev_reg & ~delayed_result)
                    : (~delayed_prev_reg & delayed_result);

    assign ctrl_rd = bus.rd & addr_is(bus.addr, acmp_pkg::CMP_CONTROL_ADDR);

    // ------------------------------------------------------------------
    // Event flag
    // ------------------------------------------------------------------
    // Read clears, set wins
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            flag_reg <= 1'b0;
        end else if (ce_in) begin
            if (edge_hit) begin
                flag_reg <= 1'b1;
            end else if (ctrl_rd) begin
                flag_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control and reference registers
    // ------------------------------------------------------------------
    // Enable reset clear
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            control_reg    <= acmp_pkg::CMP_CONTROL_RST;
            ref_select_reg <= acmp_pkg::REF_SELECT_RST;
        end else if (ce_in) begin
            if (bus.wr && addr_is(bus.addr, acmp_pkg::CMP_CONTROL_ADDR)) begin
                control_reg[acmp_pkg::CC_HYST]  <=
                    bus.wdata[acmp_pkg::CC_HYST];
                control_reg[acmp_pkg::CC_INV]   <=
                    bus.wdata[acmp_pkg::CC_INV];
                control_reg[acmp_pkg::CC_IE]    <=
                    bus.wdata[acmp_pkg::CC_IE];
                control_reg[acmp_pkg::CC_PIN]   <=
                    bus.wdata[acmp_pkg::CC_PIN];
                control_reg[acmp_pkg::CC_POWER] <=
                    bus.wdata[acmp_pkg::CC_POWER];
            end else if (bus.wr &&
                         addr_is(bus.addr, acmp_pkg::REF_SELECT_ADDR)) begin
                ref_select_reg <= {bus.wdata[7:2], 2'b00};
            end
            control_reg[acmp_pkg::CC_STORED] <= result_output_reg;
        end
    end

    // ------------------------------------------------------------------
    // Extra event status, clear and enable
    // ------------------------------------------------------------------
    always_comb begin
        ev_next = ev_status_reg;
        if (bus.wr && addr_is(bus.addr, acmp_pkg::IRQ_CLEAR_ADDR)) begin
            ev_next = ev_next & ~bus.wdata[acmp_pkg::EV_W-1:0];
        end
        if (edge_hit) begin
            ev_next[acmp_pkg::EV_EDGE] = 1'b1;
        end
        if (result_output_reg != result_prev_reg) begin
            ev_next[acmp_pkg::EV_CHANGE] = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            ev_status_reg <= '0;
            ev_enable_reg <= '0;
        end else if (ce_in) begin
            ev_status_reg <= ev_next;
            if (bus.wr && addr_is(bus.addr, acmp_pkg::IRQ_ENABLE_ADDR)) begin
                ev_enable_reg <= bus.wdata[acmp_pkg::EV_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_reg <= 1'b0;
        end else if (ce_in) begin
            irq_reg <= flag_reg & control_reg[acmp_pkg::CC_IE];
        end
    end

    assign comparator_irq_out = irq_reg;
    assign event_irq_out      = |(ev_status_reg & ev_enable_reg);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rdata_reg <= 8'h00;
        end else if (ce_in) begin
            rdata_reg <= 8'h00;
            if (bus.rd) begin
                if (addr_is(bus.addr, acmp_pkg::REF_SELECT_ADDR)) begin
                    rdata_reg <= ref_select_reg;
                end else if (addr_is(bus.addr,
                                     acmp_pkg::CMP_CONTROL_ADDR)) begin
                    rdata_reg <= {control_reg[7:5], flag_reg,
                                  control_reg[3:0]};
                end else if (addr_is(bus.addr,
                                     acmp_pkg::IRQ_STATUS_ADDR)) begin
                    rdata_reg <= {6'h00, ev_status_reg};
                end else if (addr_is(bus.addr,
                                     acmp_pkg::IRQ_ENABLE_ADDR)) begin
                    rdata_reg <= {6'h00, ev_enable_reg};
                end
            end
        end
    end

    assign rdata_out = rdata_reg;

    // ------------------------------------------------------------------
    // Analog controls and routing
    // ------------------------------------------------------------------
    // Power control
    assign comparator_power_out  = control_reg[acmp_pkg::CC_POWER];
    assign hysteresis_enable_out = control_reg[acmp_pkg::CC_HYST];

    always_comb begin
        reference_out.level_code =
            ref_select_reg[acmp_pkg::RS_LVL_HI:acmp_pkg::RS_LVL_LO];
        if (ref_select_reg[acmp_pkg::RS_EXT]) begin
            reference_out.source = acmp_pkg::REF_EXTERN;
        end else if (ref_select_reg[acmp_pkg::RS_BGR]) begin
            reference_out.source = acmp_pkg::REF_BANDGAP;
        end else begin
            reference_out.source = acmp_pkg::REF_LEVEL;
        end
    end

    assign port_a_pin_seven_out    = result_output_reg;
    assign port_a_pin_seven_oe_out = control_reg[acmp_pkg::CC_PIN];
    assign timer_break_out         = result_output_reg;

endmodule : acmp_control

// file: acmp_pkg.sv
package acmp_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REF_SELECT_ADDR  = 8'h2c;
    localparam logic [7:0] CMP_CONTROL_ADDR = 8'h2d;
    localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h30;
    localparam logic [7:0] IRQ_CLEAR_ADDR   = 8'h31;
    localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h32;

    localparam logic [7:0] REF_SELECT_RST   = 8'h00;
    localparam logic [7:0] CMP_CONTROL_RST  = 8'h80;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CC_HYST   = 7;
    localparam int CC_INV    = 5;
    localparam int CC_FLAG   = 4;
    localparam int CC_IE     = 3;
    localparam int CC_STORED = 2;
    localparam int CC_PIN    = 1;
    localparam int CC_POWER  = 0;
    localparam int RS_EXT    = 7;
    localparam int RS_BGR    = 6;
    localparam int RS_LVL_HI = 5;
    localparam int RS_LVL_LO = 2;

    // Extra status events: bit 0 selected-edge event (falling when inverted), bit 1 any change.
    localparam int EV_EDGE   = 0;
    localparam int EV_CHANGE = 1;
    localparam int EV_W      = 2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int IRQ_DELAY_PS  = 250000;
    localparam int IRQ_DELAY_CYC = IRQ_DELAY_PS / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        REF_LEVEL   = 2'b00,
        REF_BANDGAP = 2'b01,
        REF_EXTERN  = 2'b10
    } acmp_ref_src_t;

    typedef struct packed {
        acmp_ref_src_t source;
        logic [3:0]    level_code;
    } acmp_ref_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acmp_bus_t;

endpackage : acmp_pkg

// file: acmp_delay.sv
`timescale 1ns/1ps
module acmp_delay #(
    parameter int DEPTH = 31
) (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic resetn_in,
    input  wire logic enable_in,
    // Data
    input  wire logic d_in,
    output logic      q_out
);

    logic [DEPTH-1:0] pipe_reg;

    // ------------------------------------------------------------------
    // Shift line
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            pipe_reg <= '1;
        end else if (enable_in) begin
            pipe_reg <= {pipe_reg[DEPTH-2:0], d_in};
        end
    end

    assign q_out = pipe_reg[DEPTH-1];

endmodule : acmp_delay

// file: acmp_chk.sv
`timescale 1ns/1ps
module acmp_chk (
    // Clock and bus
    input wire logic                clk_in,
    input wire logic                resetn_in,
    input wire logic                ce_in,
    input wire logic [7:0]          addr_in,
    input wire logic [7:0]          wdata_in,
    input wire logic                wr_in,
    // Watched outputs
    input wire logic                comparator_power_out,
    input wire logic                hysteresis_enable_out,
    input wire acmp_pkg::acmp_ref_t reference_out,
    input wire logic                port_a_pin_seven_out,
    input wire logic                port_a_pin_seven_oe_out,
    input wire logic                timer_break_out,
    input wire logic                comparator_irq_out
);
    logic wc;
    logic wv;
    assign wc = ce_in && wr_in && addr_in == acmp_pkg::CMP_CONTROL_ADDR;
    assign wv = ce_in && wr_in && addr_in == acmp_pkg::REF_SELECT_ADDR;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    a_off_gives_one: assert property (
        !comparator_power_out && $past(!comparator_power_out)
        |-> port_a_pin_seven_out) else $error("output not one when off");
    a_reset_state: assert property (
        $rose(resetn_in) |-> hysteresis_enable_out
        && !comparator_power_out && !port_a_pin_seven_oe_out)
        else $error("bad state after reset");
    a_power_write: assert property (
        wc |=> comparator_power_out == $past(wdata_in[0]))
        else $error("power bit not applied");
    a_pin_enable: assert property (
        wc |=> port_a_pin_seven_oe_out == $past(wdata_in[1]))
        else $error("pin enable not applied");
    a_break_pin: assert property (
        timer_break_out == port_a_pin_seven_out)
        else $error("break differs from output");
    a_ext_wins: assert property (
        wv && wdata_in[7] |=> reference_out.source == acmp_pkg::REF_EXTERN)
        else $error("external source not chosen");
    a_level_code: assert property (
        wv && wdata_in[7:6] == 2'b00 |=> reference_out
        == {acmp_pkg::REF_LEVEL, $past(wdata_in[5:2])})
        else $error("level code not applied");
    a_irq_masked: assert property (
        wc && !wdata_in[3] |-> ##2 !comparator_irq_out)
        else $error("interrupt while disabled");
endmodule : acmp_chk

// file: acmp_core.sv
`timescale 1ns/1ps
module acmp_core (
    // Controls
    input  wire logic                power_in,
    input  wire logic                hyst_in,
    input  wire acmp_pkg::acmp_ref_t ref_in,
    input  var  int                  pos_mv_in,
    input  var  int                  ext_mv_in,
    // Result
    output logic                     result_out
);
    int   neg_mv;
    logic ready = 1'b0;
    logic noise = 1'b0;
    always #3 noise = ~noise;
    always @(power_in) begin
        ready = 1'b0;
        if (power_in) #500 ready = power_in;
    end
    always_comb begin
        if (ref_in.source == acmp_pkg::REF_EXTERN) neg_mv = ext_mv_in;
        else if (ref_in.source == acmp_pkg::REF_BANDGAP) neg_mv = 1200;
        else neg_mv = 200 * (int'(ref_in.level_code) + 1);
    end
    always @* begin
        if (!ready) result_out = noise;
        else if (pos_mv_in > neg_mv + (hyst_in ? 10 : 0)) result_out = 1'b1;
        else if (pos_mv_in < neg_mv - (hyst_in ? 10 : 0)) result_out = 1'b0;
    end
endmodule : acmp_core

// file: acmp_control_tb.sv
`timescale 1ns/1ps
module acmp_control_tb;
    logic                clk_in    = 1'b0;
    logic                resetn_in = 1'b0;
    logic [7:0]          addr_in   = 8'h00;
    logic [7:0]          wdata_in  = 8'h00;
    logic                wr_in     = 1'b0;
    logic                rd_in     = 1'b0;
    logic                ce        = 1'b1;
    logic [7:0]          rdata_out, rv;
    logic                raw, pwr, hyst, pin, oe, brk, irq, eirq;
    acmp_pkg::acmp_ref_t refv;
    int                  pos_mv = 1100;
    int                  ext_mv = 2000;
    int                  fails = 0;
    int                  checks_done = 0;
    int                  k;
    localparam logic [7:0] CC = acmp_pkg::CMP_CONTROL_ADDR;
    always #4 clk_in = ~clk_in;
    acmp_control acmp_control_i (.clk_in(clk_in), .resetn_in(resetn_in),
        .ce_in(ce), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .raw_result_in(raw),
        .comparator_power_out(pwr), .hysteresis_enable_out(hyst),
        .reference_out(refv), .port_a_pin_seven_out(pin),
        .port_a_pin_seven_oe_out(oe), .timer_break_out(brk),
        .comparator_irq_out(irq), .event_irq_out(eirq));
    acmp_core acmp_core_i (.power_in(pwr), .hyst_in(hyst), .ref_in(refv),
        .pos_mv_in(pos_mv), .ext_mv_in(ext_mv), .result_out(raw));
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out;
    endtask : rd
    task automatic wait_on(ref logic s, input logic v);
        k = 0;
        while (s !== v && k < 200) begin
            @(negedge clk_in);
            k++;
        end
        if (s !== v) begin
            fails++;
            test_done();
        end
    endtask : wait_on
    task automatic t_reset;
        rd(acmp_pkg::REF_SELECT_ADDR);
        chk(rv, 8'h00);
        rd(CC);
        chk(rv, 8'h84);
        rd(8'h2e);
        chk(rv, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_ref;
        wr(acmp_pkg::REF_SELECT_ADDR, 8'hff);
        rd(acmp_pkg::REF_SELECT_ADDR);
        chk(rv, 8'hfc);
        chk({6'h00, refv.source}, 8'h02);
        wr(acmp_pkg::REF_SELECT_ADDR, 8'h7c);
        chk({6'h00, refv.source}, 8'h01);
        for (int c = 0; c < 16; c++) begin
            wr(acmp_pkg::REF_SELECT_ADDR, {2'b00, c[3:0], 2'b00});
            chk({2'b00, refv}, {4'h0, c[3:0]});
        end
        $display("t_ref done");
    endtask : t_ref
    task automatic t_compare;
        wr(acmp_pkg::REF_SELECT_ADDR, 8'h40);
        pos_mv = 1300;
        wr(CC, 8'h81);
        chk({7'h00, pwr}, 8'h01);
        repeat (70) @(posedge clk_in);
        rd(CC);
        chk(rv & 8'h04, 8'h04);
        pos_mv = 1100;
        repeat (8) @(posedge clk_in);
        rd(CC);
        chk(rv & 8'h04, 8'h00);
        $display("t_compare done");
    endtask : t_compare
    task automatic t_invert;
        pos_mv = 1300;
        wr(CC, 8'h83);
        wait_on(pin, 1'b1);
        chk({7'h00, oe}, 8'h01);
        wr(CC, 8'ha3);
        wait_on(pin, 1'b0);
        chk({7'h00, brk}, 8'h00);
        $display("t_invert done");
    endtask : t_invert
    task automatic t_flag;
        for (int i = 0; i < 2; i++) begin
            pos_mv = 1100;
            wr(CC, {2'b10, i[0], 5'b01001});
            repeat (45) @(posedge clk_in);
            rd(CC);
            pos_mv = 1300;
            wait_on(pin, ~i[0]);
            wait_on(irq, 1'b1);
            chk(8'(k >= 31 && k <= 36), 8'h01);
            rd(CC);
            chk(rv & 8'h10, 8'h10);
            wr(CC, {2'b10, i[0], 5'b11001});
            rd(CC);
            chk(rv & 8'h10, 8'h00);
            chk({7'h00, irq}, 8'h00);
            pos_mv = 1100;
            repeat (50) @(posedge clk_in);
            chk({7'h00, irq}, 8'h00);
        end
        $display("t_flag done");
    endtask : t_flag
    task automatic t_events;
        wr(acmp_pkg::IRQ_ENABLE_ADDR, 8'h02);
        pos_mv = 1300;
        wait_on(eirq, 1'b1);
        rd(acmp_pkg::IRQ_STATUS_ADDR);
        chk(rv & 8'h02, 8'h02);
        wr(acmp_pkg::IRQ_ENABLE_ADDR, 8'h00);
        chk({7'h00, eirq}, 8'h00);
        wr(acmp_pkg::IRQ_ENABLE_ADDR, 8'h02);
        chk({7'h00, eirq}, 8'h01);
        wr(acmp_pkg::IRQ_CLEAR_ADDR, 8'h03);
        chk({7'h00, eirq}, 8'h00);
        rd(acmp_pkg::IRQ_STATUS_ADDR);
        chk(rv, 8'h00);
        $display("t_events done");
    endtask : t_events
    task automatic t_freeze;
        @(posedge clk_in);
        ce <= 1'b0;
        wr(acmp_pkg::REF_SELECT_ADDR, 8'h80);
        chk({6'h00, refv.source}, 8'h01);
        @(posedge clk_in);
        ce <= 1'b1;
        $display("t_freeze done");
    endtask : t_freeze
    task automatic t_off;
        wr(CC, 8'ha2);
        wait_on(pin, 1'b1);
        for (int i = 0; i < 6; i++) begin
            repeat (3) @(posedge clk_in);
            chk({6'h00, brk, pin}, 8'h03);
        end
        $display("t_off done");
    endtask : t_off
    initial begin
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset();
        t_ref();
        t_compare();
        t_invert();
        t_flag();
        t_events();
        t_freeze();
        t_off();
        test_done();
    end
endmodule : acmp_control_tb
bind acmp_control acmp_chk acmp_chk_i (.*);
